// ### tid_pkg.sv
// package of field layouts, operand codes and reset values for the transfer decoder
`default_nettype none
package tid_pkg;
  // ----------------------------------------
  // instruction word layout
  // ----------------------------------------
  localparam int TID_FMT_BIT = 15;
  localparam int TID_DST_MSB = 14;
  localparam int TID_DST_LSB = 8;
  localparam int TID_SRC_MSB = 7;
  localparam int TID_SRC_LSB = 0;
  // operand split: low 4 bits module, upper bits index
  localparam int TID_MOD_W = 4;
  localparam int TID_ACC_N = 16;
  localparam logic [15:0] TID_PC_RST = 16'h0000;
  localparam logic [15:0] TID_DP_RST = 16'h0000;
  localparam logic [3:0] TID_AIX_RST = 4'h0;
  localparam logic [4:0] TID_FLG_RST = 5'h00;
  // flag bit positions in the processor_flag_register
  localparam int TID_F_C = 0;
  localparam int TID_F_Z = 1;
  localparam int TID_F_S = 2;
  localparam int TID_F_E = 3;
  localparam int TID_F_O = 4;
  // ----------------------------------------
  // operand modules
  // ----------------------------------------
  localparam logic [3:0] TID_M_ACC = 4'h0; // accumulator array, direct
  localparam logic [3:0] TID_M_SYS = 4'h1; // system registers and portals
  localparam logic [3:0] TID_M_ALU = 4'h2; // alu triggers, destination only
  localparam logic [3:0] TID_M_JMP = 4'h3; // conditional jumps, destination only
  // system module indexes
  localparam logic [3:0] TID_S_ACT = 4'h0; // active accumulator
  localparam logic [3:0] TID_S_AIX = 4'h1; // accumulator_index_register
  localparam logic [3:0] TID_S_DP0 = 4'h2; // pointer_zero register
  localparam logic [3:0] TID_S_IND = 4'h3; // indirect_pointer_access
  localparam logic [3:0] TID_S_PINC = 4'h4; // post_increment_access
  localparam logic [3:0] TID_S_PDEC = 4'h5; // post_decrement_access
  localparam logic [3:0] TID_S_FLG = 4'h6; // processor_flag_register
  localparam logic [3:0] TID_S_PC = 4'h7; // program_counter, unconditional jump
  localparam logic [3:0] TID_S_AIND = 4'h8; // accumulator at pointer_zero low bits
  // alu indexes
  localparam logic [3:0] TID_A_ADD = 4'h0;
  localparam logic [3:0] TID_A_SUB = 4'h1;
  localparam logic [3:0] TID_A_ADD_WITH_CARRY = 4'h2;
  localparam logic [3:0] TID_A_SUBTRACT_WITH_BORROW = 4'h3;
  // decoded operand
  typedef struct packed {
    logic [3:0] modsel;
    logic [3:0] idx;
  } tid_opnd_t;
  // data memory request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } tid_dmem_t;
endpackage
`default_nettype wire

// ### tid_opnd_dec.sv
// operand field splitter shared by source and destination
`default_nettype none
module tid_opnd_dec (
  input wire logic [7:0] field_in,
  input wire logic en_in,
  output tid_pkg::tid_opnd_t opnd_out,
  output logic [15:0] mod_hot_out
);
  import tid_pkg::*;
  // same fixed split for both fields; mod_hot_out idle when not enabled
  always_comb begin
    opnd_out.modsel = field_in[TID_MOD_W-1:0]; // [RL16]
    opnd_out.idx = field_in[7:TID_MOD_W];
    mod_hot_out = en_in ? (16'h0001 << field_in[TID_MOD_W-1:0]) : 16'h0000; // [RL11]
  end
endmodule
`default_nettype wire

// ### tid_core.sv
// single-cycle transfer instruction fetch, decode and execute unit
//
// Function
// RL1 - 16-bit word: format, dest, source transfer
// RL2 - format zero: source is immediate byte
// RL3 - format one: source decoded module/index
// RL4 - every instruction completes in one cycle
// RL5 - fetch, decode, execute same cycle, no pipeline
// RL6 - portal operands address memory via pointer
// RL7 - pointer portal reads or writes data memory
// RL8 - post inc/dec portals adjust pointer after read
// RL9 - alu destinations operate on active accumulator
// RL10 - per-flag jump destinations load program counter
// RL11 - unselected modules see no switching
// RL12 - only needed circuits receive clock; the core clocks all registers each edge and only outputs mod_clk_en_out
// RL13 - any source pairs with any destination
// RL14 - alu result written to active accumulator
// RL15 - jumps test carry zero sign equal overflow
// RL16 - fixed identical module/index field split
// RL17 - reset clears counter, blocks memory write; srst_in blocks the write, arst_n_in does not
`default_nettype none
module tid_core (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic srst_in,
  input wire logic [15:0] instr_in,
  input wire logic [7:0] dmem_rdata_in,
  output logic [15:0] pmem_addr_out,
  output tid_pkg::tid_dmem_t dmem_out,
  output logic [7:0] acc_active_out,
  output logic [4:0] flags_out,
  output logic [15:0] mod_clk_en_out
);
  import tid_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] pc_r, pc_nxt;
  logic [15:0] dp_r, dp_nxt;
  logic [3:0] aix_r, aix_nxt;
  logic [4:0] flg_r, flg_nxt;
  logic [7:0] acc_r [TID_ACC_N];
  logic [7:0] acc_nxt [TID_ACC_N];

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic fmt;
  logic [7:0] dst_field;
  tid_opnd_t dst, src;
  logic [15:0] dst_hot, src_hot;
  logic [7:0] src_val;

  // split of the instruction word
  assign fmt = instr_in[TID_FMT_BIT]; // [RL1]
  assign dst_field = {1'b0, instr_in[TID_DST_MSB:TID_DST_LSB]};

  tid_opnd_dec u_dst (
    .field_in(dst_field),
    .en_in(1'b1),
    .opnd_out(dst),
    .mod_hot_out(dst_hot)
  );
  tid_opnd_dec u_src (
    .field_in(instr_in[TID_SRC_MSB:TID_SRC_LSB]),
    .en_in(fmt), // [RL11]
    .opnd_out(src),
    .mod_hot_out(src_hot)
  );

  // sum with carry-in, one extra bit for carry out
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic ci);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction

  // overflow of an 8-bit signed add
  function automatic logic ovf(input logic [7:0] a, input logic [7:0] b,
                               input logic [7:0] r);
    ovf = (a[7] == b[7]) && (r[7] != a[7]);
  endfunction

  // source read: immediate or any module/index, no pairing limits
  always_comb begin
    src_val = 8'h00;
    if (!fmt) begin
      src_val = instr_in[TID_SRC_MSB:TID_SRC_LSB]; // [RL2]
    end else begin
      unique case (src.modsel) // [RL3] [RL13]
        TID_M_ACC: src_val = acc_r[src.idx];
        TID_M_SYS: begin
          unique case (src.idx)
            TID_S_ACT: src_val = acc_r[aix_r];
            TID_S_AIX: src_val = {4'h0, aix_r};
            TID_S_DP0: src_val = dp_r[7:0];
            TID_S_IND, TID_S_PINC, TID_S_PDEC: src_val = dmem_rdata_in; // [RL7]
            TID_S_FLG: src_val = {3'h0, flg_r};
            TID_S_PC: src_val = pc_r[7:0];
            TID_S_AIND: src_val = acc_r[dp_r[3:0]]; // [RL6]
            default: src_val = 8'h00;
          endcase
        end
        default: src_val = 8'h00;
      endcase
    end
  end

  // memory requests addressed by pointer_zero
  logic src_mem, dst_mem;
  assign src_mem = fmt && (src.modsel == TID_M_SYS) &&
                   (src.idx == TID_S_IND || src.idx == TID_S_PINC || src.idx == TID_S_PDEC);
  assign dst_mem = (dst.modsel == TID_M_SYS) && (dst.idx == TID_S_IND);
  always_comb begin
    dmem_out.rd = src_mem && !srst_in; // [RL6] [RL7]
    dmem_out.wr = dst_mem && !srst_in; // [RL7] [RL17]
    dmem_out.addr = dp_r; // [RL6]
    dmem_out.wdata = dst_mem ? src_val : 8'h00; // [RL11]
  end

  // ----------------------------------------
  // execute: next state in one cycle
  // ----------------------------------------
  logic [8:0] sum;
  logic take;
  always_comb begin
    pc_nxt = pc_r + 16'h0001; // [RL5]
    dp_nxt = dp_r;
    aix_nxt = aix_r;
    flg_nxt = flg_r;
    for (int i = 0; i < TID_ACC_N; i++) begin
      acc_nxt[i] = acc_r[i];
    end
    sum = 9'h000;
    take = 1'b0;
    // post adjust of the pointer after the read
    if (src_mem && src.idx == TID_S_PINC) begin
      dp_nxt = dp_r + 16'h0001; // [RL8]
    end else if (src_mem && src.idx == TID_S_PDEC) begin
      dp_nxt = dp_r - 16'h0001; // [RL8]
    end
    unique case (dst.modsel)
      TID_M_ACC: acc_nxt[dst.idx] = src_val;
      TID_M_SYS: begin
        unique case (dst.idx)
          TID_S_ACT: acc_nxt[aix_r] = src_val;
          TID_S_AIX: aix_nxt = src_val[3:0];
          TID_S_DP0: dp_nxt = {dp_r[15:8], src_val};
          TID_S_FLG: flg_nxt = src_val[4:0];
          TID_S_PC: pc_nxt = {8'h00, src_val};
          TID_S_AIND: acc_nxt[dp_r[3:0]] = src_val; // [RL6]
          default: ;
        endcase
      end
      TID_M_ALU: begin
        // alu result into the active accumulator
        unique case (dst.idx) // [RL9]
          TID_A_ADD: sum = add9(acc_r[aix_r], src_val, 1'b0);
          TID_A_ADD_WITH_CARRY: sum = add9(acc_r[aix_r], src_val, flg_r[TID_F_C]);
          TID_A_SUB: sum = add9(acc_r[aix_r], ~src_val, 1'b1);
          TID_A_SUBTRACT_WITH_BORROW: sum = add9(acc_r[aix_r], ~src_val, ~flg_r[TID_F_C]);
          default: sum = {1'b0, acc_r[aix_r]};
        endcase
        if (dst.idx <= TID_A_SUBTRACT_WITH_BORROW) begin
          acc_nxt[aix_r] = sum[7:0]; // [RL14]
          flg_nxt[TID_F_C] = (dst.idx == TID_A_SUB || dst.idx == TID_A_SUBTRACT_WITH_BORROW) ?
                             ~sum[8] : sum[8];
          flg_nxt[TID_F_Z] = (sum[7:0] == 8'h00);
          flg_nxt[TID_F_S] = sum[7];
          flg_nxt[TID_F_E] = (acc_r[aix_r] == src_val);
          flg_nxt[TID_F_O] = (dst.idx == TID_A_SUB || dst.idx == TID_A_SUBTRACT_WITH_BORROW) ?
                             ovf(acc_r[aix_r], ~src_val, sum[7:0]) :
                             ovf(acc_r[aix_r], src_val, sum[7:0]);
        end
      end
      TID_M_JMP: begin
        // index 0..4 selects flag set; dst index bit 3 is tied low, so the 8..12 flag clear codes never occur
        if (dst.idx[2:0] <= 3'h4) begin
          take = flg_r[dst.idx[2:0]] ^ dst.idx[3]; // [RL15]
        end
        if (take) begin
          pc_nxt = {8'h00, src_val}; // [RL10]
        end
      end
      default: ;
    endcase
    if (srst_in) begin
      pc_nxt = TID_PC_RST; // [RL17]
    end
  end

  // register everything each edge, every instruction one cycle
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pc_r <= TID_PC_RST;
      dp_r <= TID_DP_RST;
      aix_r <= TID_AIX_RST;
      flg_r <= TID_FLG_RST;
      for (int i = 0; i < TID_ACC_N; i++) begin
        acc_r[i] <= 8'h00;
      end
    end else begin
      pc_r <= pc_nxt; // [RL4]
      dp_r <= dp_nxt;
      aix_r <= aix_nxt;
      flg_r <= flg_nxt;
      for (int i = 0; i < TID_ACC_N; i++) begin
        acc_r[i] <= acc_nxt[i];
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pmem_addr_out = pc_r; // [RL5]
  assign acc_active_out = acc_r[aix_r];
  assign flags_out = flg_r;
  // per-module clock enables for an external gating cell
  assign mod_clk_en_out = dst_hot | src_hot; // [RL12]

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_reset_cyc;
    srst_in;
  endsequence
  a_reset_pc_clear: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    s_reset_cyc |=> pc_r == TID_PC_RST) else $error("pc not cleared"); // [RL17]
  a_reset_no_wr: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    srst_in |-> !dmem_out.wr) else $error("write during reset"); // [RL17]
  a_seq_pc_step: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (!srst_in && dst.modsel != TID_M_JMP && !(dst.modsel == TID_M_SYS && dst.idx == TID_S_PC))
    |=> pc_r == $past(pc_r) + 16'h0001) else $error("pc not advanced"); // [RL4]
  a_imm_literal: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !fmt |-> src_val == instr_in[7:0]) else $error("immediate wrong"); // [RL2]
  // only a pointer destination overrides the post adjust
  a_post_inc_ptr: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (src_mem && src.idx == TID_S_PINC && !(dst.modsel == TID_M_SYS && dst.idx == TID_S_DP0)) |=>
    dp_r == $past(dp_r) + 16'h0001) else $error("pointer not incremented"); // [RL8]
  a_post_dec_ptr: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (src_mem && src.idx == TID_S_PDEC && !(dst.modsel == TID_M_SYS && dst.idx == TID_S_DP0)) |=>
    dp_r == $past(dp_r) - 16'h0001) else $error("pointer not decremented"); // [RL8]
  a_mem_addr_ptr: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (dmem_out.rd || dmem_out.wr) |-> dmem_out.addr == dp_r) else $error("bad address"); // [RL7]
  a_jump_taken: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (take && !srst_in) |=> pc_r == {8'h00, $past(src_val)}) else $error("jump lost"); // [RL10]
  a_add_result: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (dst.modsel == TID_M_ALU && dst.idx == TID_A_ADD) |=>
    acc_r[$past(aix_r)] == $past(acc_r[aix_r]) + $past(src_val)) else $error("add wrong"); // [RL14]
  a_idle_module: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !fmt |-> mod_clk_en_out == dst_hot) else $error("source module toggled"); // [RL11]
endmodule
`default_nettype wire

// ### tid_mem_model.sv
// program and data memory model facing the transfer decoder core
`default_nettype none
module tid_mem_model (
  input wire logic mclk_in,
  input wire logic [15:0] pmem_addr_in,
  input wire tid_pkg::tid_dmem_t dmem_in,
  output logic [15:0] instr_out,
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import tid_pkg::*;
  logic [15:0] prog [256];
  logic [7:0] data [256];
  logic [7:0] last_r = 8'h5a;
  // same-cycle fetch, no pipeline in front of the core
  assign instr_out = prog[pmem_addr_in[7:0]];
  // unstrobed reads show the inverse of the last byte, never a stale copy
  assign rdata_out = dmem_in.rd ? data[dmem_in.addr[7:0]] : ~last_r;
  // write lands at the edge that ends the instruction
  always @(posedge mclk_in) begin
    if (dmem_in.rd) last_r <= data[dmem_in.addr[7:0]];
    if (dmem_in.wr) data[dmem_in.addr[7:0]] <= dmem_in.wdata;
  end
endmodule
`default_nettype wire

// ### transfer_instruction_decoder_tb.sv
// self-checking bench for the transfer decoder core
`default_nettype none
module transfer_instruction_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tid_pkg::*;
  localparam logic [15:0] NOP = 16'h0f00; // undefined destination module
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic srst_in = 1'b0;
  logic [15:0] instr, pc, clk_en;
  logic [7:0] rdata, acc;
  logic [4:0] flags;
  tid_dmem_t dmem;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #4 mclk_in = ~mclk_in;
  tid_core dut_u (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .srst_in(srst_in),
    .instr_in(instr), .dmem_rdata_in(rdata), .pmem_addr_out(pc), .dmem_out(dmem),
    .acc_active_out(acc), .flags_out(flags), .mod_clk_en_out(clk_en));
  tid_mem_model mem_u (.mclk_in(mclk_in), .pmem_addr_in(pc), .dmem_in(dmem),
    .instr_out(instr), .rdata_out(rdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] ins(input logic f, input logic [3:0] dm,
                                     input logic [2:0] di, input logic [7:0] s);
    return {f, di, dm, s};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step();
    @(negedge mclk_in);
  endtask
  // nops during the restart cycle, then the program from address zero
  task automatic load(input logic [15:0] p[$]);
    for (int i = 0; i < 256; i++) mem_u.prog[i] = NOP;
    srst_in = 1'b1;
    step();
    srst_in = 1'b0;
    foreach (p[i]) mem_u.prog[i] = p[i];
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_alu();
    logic [7:0] ea[4] = '{8'h10, 8'h12, 8'hff, 8'hfe};
    logic ec[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    load('{ins(0, TID_M_SYS, 3'h1, 8'h02), ins(0, TID_M_SYS, 3'h0, 8'hf0),
      ins(0, TID_M_ALU, 3'h0, 8'h20), ins(0, TID_M_ALU, 3'h2, 8'h01),
      ins(0, TID_M_ALU, 3'h1, 8'h13), ins(0, TID_M_ALU, 3'h3, 8'h00),
      ins(0, TID_M_SYS, 3'h1, 8'h00), ins(1, TID_M_SYS, 3'h2, 8'h20)});
    step();
    step();
    chk("imm acc", 16'h00f0, {8'h00, acc});
    chk("alu clk en", 16'h0004, clk_en);
    for (int i = 0; i < 4; i++) begin
      step();
      chk("alu acc", {8'h00, ea[i]}, {8'h00, acc});
      chk("carry", {15'h0, ec[i]}, {15'h0, flags[TID_F_C]});
      chk("sign", {15'h0, ea[i][7]}, {15'h0, flags[TID_F_S]});
      chk("pc", 16'(i + 3), pc);
    end
    step();
    chk("other acc", 16'h0000, {8'h00, acc});
    chk("mixed clk en", 16'h0003, clk_en);
    step();
    chk("acc to pointer", 16'h00fe, dmem.addr);
  endtask
  task automatic t_mem();
    mem_u.data[8'h11] = 8'h3c;
    load('{ins(0, TID_M_SYS, 3'h2, 8'h10), ins(0, TID_M_SYS, 3'h3, 8'ha5),
      ins(1, TID_M_SYS, 3'h0, 8'h41), ins(1, TID_M_SYS, 3'h0, 8'h51),
      ins(1, TID_M_SYS, 3'h0, 8'h31)});
    step();
    chk("wr req", {1'b1, 15'h0010}, {dmem.wr, dmem.addr[14:0]});
    chk("wdata", 16'h00a5, {8'h00, dmem.wdata});
    step();
    chk("mem byte", 16'h00a5, {8'h00, mem_u.data[8'h10]});
    chk("rd inc", {1'b1, 15'h0010}, {dmem.rd, dmem.addr[14:0]});
    step();
    chk("inc data", {8'h00, 8'ha5}, {8'h00, acc});
    chk("inc ptr", 16'h0011, dmem.addr);
    step();
    chk("dec data", 16'h003c, {8'h00, acc});
    chk("dec ptr", 16'h0010, dmem.addr);
    step();
    chk("ind data", 16'h00a5, {8'h00, acc});
    // pointer write fetched while restart is held must not land
    mem_u.prog[5] = ins(0, TID_M_SYS, 3'h3, 8'h5a);
    srst_in = 1'b1;
    #1;
    chk("wr in reset", 16'h0000, {15'h0, dmem.wr});
    step();
    // restart stays high, the next load restarts anyway
    chk("mem kept", 16'h00a5, {8'h00, mem_u.data[8'h10]});
    chk("pc cleared", 16'h0000, pc);
  endtask
  task automatic t_jump();
    for (int n = 0; n < 5; n++) begin
      for (int t = 0; t < 2; t++) begin
        load('{ins(0, TID_M_SYS, 3'h6, t ? 8'h00 : 8'(1 << n)),
          ins(0, TID_M_JMP, 3'(n), 8'h40)});
        step();
        chk("jmp clk en", 16'h0008, clk_en);
        step();
        chk("jmp pc", t ? 16'h0002 : 16'h0040, pc);
      end
    end
    load('{ins(0, TID_M_SYS, 3'h7, 8'h80)});
    step();
    chk("uncond pc", 16'h0080, pc);
  endtask
  // direct acc dest, acc portal source, zero/equal/overflow, pc source
  task automatic t_portal();
    logic [7:0] ea[5] = '{8'h77, 8'h00, 8'h80, 8'h00, 8'h06};
    logic [4:0] ef[5] = '{5'h00, 5'h0a, 5'h04, 5'h1b, 5'h1b};
    load('{ins(0, TID_M_SYS, 3'h2, 8'h05), ins(0, TID_M_ACC, 3'h5, 8'h77),
      ins(1, TID_M_SYS, 3'h0, 8'h81), ins(0, TID_M_ALU, 3'h1, 8'h77),
      ins(0, TID_M_ALU, 3'h0, 8'h80), ins(0, TID_M_ALU, 3'h0, 8'h80),
      ins(1, TID_M_SYS, 3'h0, 8'h71)});
    step();
    step();
    for (int i = 0; i < 5; i++) begin
      step();
      chk("portal acc", {8'h00, ea[i]}, {8'h00, acc});
      chk("portal flags", {11'h000, ef[i]}, {11'h000, flags});
    end
  endtask
  // ----------------------------------------
  // main sequence and hang limit
  // ----------------------------------------
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    for (int i = 0; i < 256; i++) mem_u.prog[i] = NOP;
    repeat (6) step();
    chk("rst pc", TID_PC_RST, pc);
    chk("rst ptr", TID_DP_RST, dmem.addr);
    chk("rst acc flg", {3'h0, TID_FLG_RST, 8'h00}, {3'h0, flags, acc});
    arst_n_in = 1'b1;
    t_alu();
    t_mem();
    t_jump();
    t_portal();
    stop_test();
  end
endmodule
`default_nettype wire
